/* File: rtl/ccdo_cfg.svh */
`ifndef CCDO_CFG_SVH
`define CCDO_CFG_SVH

// ****************************************************************
// Register byte offsets on the APB bus.
// ****************************************************************
`define CCDO_OFF_CMD 12'h000
`define CCDO_OFF_WREG 12'h004
`define CCDO_OFF_STAT 12'h008
`define CCDO_OFF_CTRL 12'h00C
`define CCDO_OFF_WDT 12'h010
`define CCDO_OFF_PRE 12'h014
`define CCDO_FILE_PAGE 4'h1

// ****************************************************************
// Field positions.
// ****************************************************************
`define CCDO_CMD_OP_LSB 0
`define CCDO_CMD_DST 3
`define CCDO_CMD_ADR_LSB 8
`define CCDO_ST_Z 0
`define CCDO_ST_C 1
`define CCDO_ST_TO 2
`define CCDO_ST_PD 3
`define CCDO_ST_SKP 4
`define CCDO_CTRL_ASG 0

// ****************************************************************
// Reset values and cycle counts.
// ****************************************************************
`define CCDO_RST_BYTE 8'h00
`define CCDO_RST_FLAG 1'b1
`define CCDO_RST_ASG 1'b1
`define CCDO_SKIP_CYCLES 2

`endif

/* File: rtl/ccdo_pkg.sv */
package ccdo_pkg;

    // Instruction codes written into the command field.
    typedef enum logic [2:0] {
        OP_NOP = 3'b000,
        OP_CLR_WORK = 3'b001,
        OP_WDT_CLR = 3'b010,
        OP_CLR_FILE = 3'b011,
        OP_COMP_FILE = 3'b100,
        OP_CMP_FILE = 3'b101,
        OP_DEC_FILE = 3'b110,
        OP_DEC_SKIP = 3'b111
    } ccdo_op_e;

    // Execution sequencer: the second state is the discarded slot of a skip.
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_NOP = 1'b1
    } ccdo_st_e;

    typedef logic [7:0] ccdo_byte_t;

endpackage : ccdo_pkg

/* File: rtl/ccdo_core.sv */
`include "ccdo_cfg.svh"

// Overview of operation
// RULE1 - Clearing the working register writes zero and sets the zero flag.
// RULE2 - Watchdog clear zeroes the counter, and the prescaler when assigned to it.
// RULE3 - Watchdog clear sets the expiry and sleep flags, touching no other status; the code also clears the skip flag.
// RULE4 - Clearing a file register writes zero and sets the zero flag.
// RULE5 - Complement inverts the file register, updates zero, one cycle.
// RULE6 - Destination bit zero sends result to working register, one back to file.
// RULE7 - Compare subtracts working from file register, updating zero and carry.
// RULE8 - Compare keeps both working register and file register unchanged.
// RULE9 - Decrement subtracts one, writes destination, updates only zero flag; the code also clears the skip flag, or sets it on a taken skip.
// RULE10 - Decrement-skip with zero result adds a discarded no-operation cycle.
// RULE11 - Zero set on all-zero result; compare carry set when no borrow.
module ccdo_core #(
    parameter int WDT_W = 8,
    parameter int PRE_W = 8
) (
    input wire logic CLK, // Core clock, 250 MHz.
    input wire logic RST_N, // Asynchronous reset, active low.
    input wire logic PSEL, // APB select.
    input wire logic PENABLE, // APB access phase.
    input wire logic PWRITE, // APB direction, high for write.
    input wire logic [11:0] PADDR, // APB byte address.
    input wire logic [31:0] PWDATA, // APB write data.
    output logic [31:0] PRDATA, // APB read data, registered.
    output logic PREADY, // APB ready.
    output logic PSLVERR // APB error for unmapped addresses.
);
    import ccdo_pkg::*;

    // ************************************************************
    // Reset synchroniser.
    // ************************************************************
    logic rst_s1_q;
    logic rst_n_q;

    // Release the reset through two flip-flops.
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ************************************************************
    // State and decode.
    // ************************************************************
    ccdo_byte_t mem_q [64];
    ccdo_byte_t mem_d [64];
    ccdo_byte_t w_q, w_d;
    logic z_q, z_d, c_q, c_d, to_q, to_d, pd_q, pd_d;
    logic skp_q, skp_d, asg_q, asg_d;
    logic [WDT_W-1:0] wdt_q, wdt_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    ccdo_st_e st_q, st_d;
    logic [31:0] prdata_q, prdata_d;

    ccdo_op_e op;
    logic dst;
    logic [5:0] ca;
    ccdo_byte_t fv;
    ccdo_byte_t dec_v;
    logic hit_cmd, hit_file, hit_any;
    logic skip_now, wr_acc, exec;

    // Tells whether a result is all zeros.
    function automatic logic is_zero(input ccdo_byte_t v);
        return v == `CCDO_RST_BYTE;
    endfunction : is_zero

    // Command fields come straight from the write data.
    assign op = ccdo_op_e'(PWDATA[`CCDO_CMD_OP_LSB +: 3]);
    assign dst = PWDATA[`CCDO_CMD_DST];
    assign ca = PWDATA[`CCDO_CMD_ADR_LSB +: 6];
    assign fv = mem_q[ca];
    assign dec_v = fv - 8'h01;

    // Address decode of the register page and the file window.
    assign hit_cmd = PADDR == `CCDO_OFF_CMD;
    assign hit_file = PADDR[11:8] == `CCDO_FILE_PAGE && PADDR[1:0] == 2'h0;
    assign hit_any = hit_cmd || hit_file || PADDR == `CCDO_OFF_WREG || PADDR == `CCDO_OFF_STAT
        || PADDR == `CCDO_OFF_CTRL || PADDR == `CCDO_OFF_WDT || PADDR == `CCDO_OFF_PRE;

    // A zero decrement-skip result costs one extra cycle before the command commits.
    assign skip_now = op == OP_DEC_SKIP && is_zero(dec_v) && st_q == ST_IDLE; // RULE10
    assign PREADY = !(PSEL && PENABLE && PWRITE && hit_cmd && skip_now); // RULE10
    assign PSLVERR = PSEL && PENABLE && !hit_any;
    assign wr_acc = PSEL && PENABLE && PWRITE && PREADY && hit_any;
    assign exec = wr_acc && hit_cmd;
    assign PRDATA = prdata_q;

    // ************************************************************
    // Next-state logic.
    // ************************************************************

    // Computes every register's next value except the read data, from timers, commands and writes.
    always_comb
    begin
        mem_d = mem_q;
        w_d = w_q;
        z_d = z_q;
        c_d = c_q;
        to_d = to_q;
        pd_d = pd_q;
        skp_d = skp_q;
        asg_d = asg_q;
        st_d = st_q;
        pre_d = pre_q + 1'b1;
        wdt_d = wdt_q;
        if (!asg_q || pre_q == '1)
        begin
            wdt_d = wdt_q + 1'b1;
            if (wdt_q == '1)
            begin
                to_d = 1'b0;
            end
        end
        if (PSEL && PENABLE && PWRITE && hit_cmd && skip_now)
        begin
            st_d = ST_NOP;
        end
        if (exec)
        begin
            st_d = ST_IDLE;
            skp_d = 1'b0;
            unique case (op)
                OP_NOP:
                begin
                end
                OP_CLR_WORK:
                begin
                    w_d = `CCDO_RST_BYTE; // RULE1
                    z_d = 1'b1; // RULE1
                end
                OP_WDT_CLR:
                begin
                    wdt_d = '0; // RULE2
                    if (asg_q)
                    begin
                        pre_d = '0; // RULE2
                    end
                    to_d = 1'b1; // RULE3
                    pd_d = 1'b1; // RULE3
                end
                OP_CLR_FILE:
                begin
                    mem_d[ca] = `CCDO_RST_BYTE; // RULE4
                    z_d = 1'b1; // RULE4
                end
                OP_COMP_FILE:
                begin
                    if (dst)
                    begin
                        mem_d[ca] = ~fv; // RULE5 RULE6
                    end
                    else
                    begin
                        w_d = ~fv; // RULE5 RULE6
                    end
                    z_d = is_zero(~fv); // RULE11
                end
                OP_CMP_FILE:
                begin
                    z_d = is_zero(fv - w_q); // RULE7 RULE8 RULE11
                    c_d = fv >= w_q; // RULE7 RULE11
                end
                OP_DEC_FILE, OP_DEC_SKIP:
                begin
                    if (dst)
                    begin
                        mem_d[ca] = dec_v; // RULE9 RULE6
                    end
                    else
                    begin
                        w_d = dec_v; // RULE9 RULE6
                    end
                    z_d = is_zero(dec_v); // RULE9 RULE11
                    skp_d = op == OP_DEC_SKIP && st_q == ST_NOP; // RULE10
                end
            endcase
        end
        else if (wr_acc)
        begin
            if (hit_file)
            begin
                mem_d[PADDR[7:2]] = PWDATA[7:0];
            end
            if (PADDR == `CCDO_OFF_WREG)
            begin
                w_d = PWDATA[7:0];
            end
            if (PADDR == `CCDO_OFF_STAT)
            begin
                z_d = PWDATA[`CCDO_ST_Z];
                c_d = PWDATA[`CCDO_ST_C];
                to_d = PWDATA[`CCDO_ST_TO];
                pd_d = PWDATA[`CCDO_ST_PD];
            end
            if (PADDR == `CCDO_OFF_CTRL)
            begin
                asg_d = PWDATA[`CCDO_CTRL_ASG];
            end
        end
    end

    // Read data is captured in the setup cycle and held through the access.
    always_comb
    begin
        prdata_d = prdata_q;
        if (PSEL && !PENABLE && !PWRITE)
        begin
            prdata_d = 32'h0000_0000;
            if (hit_file)
            begin
                prdata_d[7:0] = mem_q[PADDR[7:2]];
            end
            else if (PADDR == `CCDO_OFF_WREG)
            begin
                prdata_d[7:0] = w_q;
            end
            else if (PADDR == `CCDO_OFF_STAT)
            begin
                prdata_d[4:0] = {skp_q, pd_q, to_q, c_q, z_q};
            end
            else if (PADDR == `CCDO_OFF_CTRL)
            begin
                prdata_d[0] = asg_q;
            end
            else if (PADDR == `CCDO_OFF_WDT)
            begin
                prdata_d[WDT_W-1:0] = wdt_q;
            end
            else if (PADDR == `CCDO_OFF_PRE)
            begin
                prdata_d[PRE_W-1:0] = pre_q;
            end
        end
    end

    // ************************************************************
    // Registers.
    // ************************************************************

    // Registers all state on every edge.
    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            for (int i = 0; i < 64; i++)
            begin
                mem_q[i] <= `CCDO_RST_BYTE;
            end
            w_q <= `CCDO_RST_BYTE;
            z_q <= 1'b0;
            c_q <= 1'b0;
            to_q <= `CCDO_RST_FLAG;
            pd_q <= `CCDO_RST_FLAG;
            skp_q <= 1'b0;
            asg_q <= `CCDO_RST_ASG;
            wdt_q <= '0;
            pre_q <= '0;
            st_q <= ST_IDLE;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            mem_q <= mem_d;
            w_q <= w_d;
            z_q <= z_d;
            c_q <= c_d;
            to_q <= to_d;
            pd_q <= pd_d;
            skp_q <= skp_d;
            asg_q <= asg_d;
            wdt_q <= wdt_d;
            pre_q <= pre_d;
            st_q <= st_d;
            prdata_q <= prdata_d;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!rst_n_q);

    a_clear_work_zero: assert property (exec && op == OP_CLR_WORK |=> w_q == 8'h00 && z_q) // RULE1
        else $error("Working register clear failed.");
    a_wdt_count_zero: assert property (exec && op == OP_WDT_CLR |=> wdt_q == '0) // RULE2
        else $error("Watchdog counter not cleared.");
    a_prescaler_cleared: assert property (exec && op == OP_WDT_CLR && asg_q |=> pre_q == '0) // RULE2
        else $error("Assigned prescaler not cleared.");
    a_wdt_status_set: assert property (exec && op == OP_WDT_CLR |=> to_q && pd_q // RULE3
        && z_q == $past(z_q) && c_q == $past(c_q))
        else $error("Watchdog clear status effect wrong.");
    a_clear_file_zero: assert property (exec && op == OP_CLR_FILE |=> mem_q[$past(ca)] == 8'h00 && z_q) // RULE4
        else $error("File register clear failed.");
    a_comp_to_work: assert property (exec && op == OP_COMP_FILE && !dst |=> w_q == ~$past(fv)) // RULE5
        else $error("Complement to working register wrong.");
    a_comp_to_file: assert property (exec && op == OP_COMP_FILE && dst // RULE6
        |=> mem_q[$past(ca)] == ~$past(fv) && w_q == $past(w_q))
        else $error("Complement to file register wrong.");
    a_cmp_keeps_data: assert property (exec && op == OP_CMP_FILE // RULE8
        |=> w_q == $past(w_q) && mem_q[$past(ca)] == $past(fv))
        else $error("Compare changed data.");
    a_cmp_flags: assert property (exec && op == OP_CMP_FILE // RULE7 RULE11
        |=> c_q == ($past(fv) >= $past(w_q)) && z_q == ($past(fv) == $past(w_q)))
        else $error("Compare flags wrong.");
    a_dec_zero_only: assert property (exec && op == OP_DEC_FILE // RULE9
        |=> c_q == $past(c_q) && z_q == ($past(fv) == 8'h01))
        else $error("Decrement flags wrong.");
    a_skip_two_cycles: assert property (PSEL && PENABLE && PWRITE && hit_cmd && skip_now // RULE10
        |-> !PREADY ##1 PREADY ##1 skp_q)
        else $error("Skip did not take two cycles.");

    c_skip_taken: cover property (exec && op == OP_DEC_SKIP && st_q == ST_NOP);
    c_cmp_borrow: cover property (exec && op == OP_CMP_FILE && fv < w_q);
    c_wdt_clear_assigned: cover property (exec && op == OP_WDT_CLR && asg_q);
    c_dec_to_file: cover property (exec && op == OP_DEC_FILE && dst);

endmodule : ccdo_core

/* File: test/test_clear_compare_decrement_ops.sv */
`include "ccdo_cfg.svh"

module test_clear_compare_decrement_ops;
    import ccdo_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] lfsr = 32'hA40BC497;
    int error_cnt = 0;
    int samples_checked = 0;

    // Core clock at 250 MHz.
    always #2 clk = ~clk;

    ccdo_core #(.WDT_W(8), .PRE_W(8)) i_dut (
        .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
    );

    // ****************************************************************
    // Helpers.
    // ****************************************************************

    // Advances the random source by one step.
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    // Predicts {skip, status, working, file} after one command.
    function automatic logic [20:0] model(input ccdo_op_e op, input logic d, input logic [7:0] f,
                                          input logic [7:0] w, input logic [3:0] s);
        logic [7:0] r;
        logic [8:0] df;
        logic sk;
        sk = 1'b0;
        r = 8'h00;
        df = 9'h000;
        case (op)
            OP_NOP:
            begin
            end
            OP_CLR_WORK:
            begin
                w = 8'h00;
                s[0] = 1'b1;
            end
            OP_WDT_CLR:
            begin
                s[3:2] = 2'b11;
            end
            OP_CLR_FILE:
            begin
                f = 8'h00;
                s[0] = 1'b1;
            end
            OP_CMP_FILE:
            begin
                df = {1'b0, f} - {1'b0, w};
                s[0] = df[7:0] == 8'h00;
                s[1] = ~df[8];
            end
            default:
            begin
                r = (op == OP_COMP_FILE) ? ~f : f - 8'h01;
                s[0] = r == 8'h00;
                sk = (op == OP_DEC_SKIP) && (r == 8'h00);
                if (d)
                begin
                    f = r;
                end
                else
                begin
                    w = r;
                end
            end
        endcase
        return {sk, s, w, f};
    endfunction : model

    // Compares one observed value against its prediction.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Prints the counts and the verdict, then stops.
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // One APB transfer with an idle cycle in front; counts wait states.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er, output int n);
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Ready is looked at mid-cycle, where it has settled for the coming edge.
        @(negedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge clk);
        end
        if (n >= 20)
        begin
            error_cnt++;
            $display("ERROR pready expected 1 seen timeout");
            summarize();
        end
        rd = prdata;
        er = pslverr;
        // The slave takes the transfer at this edge; only then is it released.
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        logic [31:0] rd, p0, p1;
        logic er;
        int n;
        logic [5:0] idx;
        logic [7:0] fv, wv;
        logic [3:0] st;
        logic d;
        ccdo_op_e op;
        logic [20:0] e;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, `CCDO_OFF_STAT, 32'h0, rd, er, n);
        chk("stat reset", rd, 32'h0000_000C);
        apb(1'b0, `CCDO_OFF_CTRL, 32'h0, rd, er, n);
        chk("ctrl reset", rd, 32'h0000_0001);
        apb(1'b0, 12'h020, 32'h0, rd, er, n);
        chk("unmapped error", {31'h0, er}, 32'h1);
        $display("reset test done");
        // Prescaler kept when unassigned, zeroed when assigned.
        for (int a = 0; a < 2; a++)
        begin
            apb(1'b1, `CCDO_OFF_CTRL, 32'(a), rd, er, n);
            apb(1'b0, `CCDO_OFF_PRE, 32'h0, p0, er, n);
            apb(1'b1, `CCDO_OFF_CMD, {29'h0, OP_WDT_CLR}, rd, er, n);
            apb(1'b0, `CCDO_OFF_PRE, 32'h0, p1, er, n);
            apb(1'b0, `CCDO_OFF_WDT, 32'h0, rd, er, n);
            if (a == 0)
                chk("prescaler kept", p1, (p0 + 32'd6) & 32'hFF);
            else
                chk("prescaler zeroed", p1, 32'h1);
            chk("watchdog zeroed", rd, (a == 0) ? 32'h4 : 32'h0);
        end
        $display("watchdog test done");
        // Random operands with forced corners: value one, equal operands, edge indices.
        for (int i = 0; i < 84; i++)
        begin
            op = ccdo_op_e'(i % 8);
            idx = (i == 0) ? 6'd0 : (i == 1) ? 6'd63 : 6'(rnd());
            fv = (i % 3 == 0) ? 8'h01 : 8'(rnd());
            wv = (i % 5 == 0) ? fv : 8'(rnd());
            st = 4'(rnd());
            d = 1'(rnd());
            apb(1'b1, {`CCDO_FILE_PAGE, idx, 2'b00}, 32'(fv), rd, er, n);
            apb(1'b1, `CCDO_OFF_WREG, 32'(wv), rd, er, n);
            apb(1'b1, `CCDO_OFF_STAT, 32'(st), rd, er, n);
            apb(1'b1, `CCDO_OFF_CMD, {18'h0, idx, 4'h0, d, op}, rd, er, n);
            e = model(op, d, fv, wv, st);
            chk("wait states", 32'(n), 32'(e[20]));
            apb(1'b0, `CCDO_OFF_WREG, 32'h0, rd, er, n);
            chk("working", rd, 32'(e[15:8]));
            apb(1'b0, {`CCDO_FILE_PAGE, idx, 2'b00}, 32'h0, rd, er, n);
            chk("file", rd, 32'(e[7:0]));
            apb(1'b0, `CCDO_OFF_STAT, 32'h0, rd, er, n);
            chk("status", rd, 32'(e[20:16]));
        end
        $display("random test done");
        summarize();
    end
endmodule : test_clear_compare_decrement_ops
